// File: src/security_erase_freeze.sv
// erase-unit and freeze-lock command engine with AXI4-Lite registers
// assumes stored passwords and lock-enable come from the security store
`timescale 1ns/1ps
`default_nettype none
module security_erase_freeze
  import security_cmd_pkg::*;
#(
  parameter int          LBA_W      = 32,
  parameter logic [15:0] ERASE_TIME = 16'h0001
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [255:0]     user_password,
  input  wire logic [255:0]     master_password,
  input  wire logic             lock_enable_set,
  input  wire logic [LBA_W-1:0] highest_native_block,
  output logic                  zero_write_valid,
  output logic [LBA_W-1:0]      zero_write_lba,
  input  wire logic             zero_write_ready,
  input  wire logic             zero_write_error,
  output logic                  frozen,
  output logic                  lock_enabled
);

  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_ERASE} engine_state_e;

  engine_state_e state_q;
  logic          aw_held_q;
  logic          w_held_q;
  logic [7:0]    waddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic [15:0]   control_q;
  logic [31:0]   password_q [PASSWORD_WORDS];
  logic [7:0]    last_cmd_q;
  logic          armed_q;
  logic          aborted_q;
  logic          not_found_q;
  logic          err_q;
  logic          start_q;
  logic          write_go;
  logic          cmd_fire;
  logic [7:0]    cmd_code;
  logic          finish_abort;
  logic          finish_ok;
  logic [255:0]  supplied_pw;

  erase_walk_if walk ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_password(input logic [7:0] addr);
    return addr[7:5] == OFF_PASSWORD[7:5];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    supplied_pw = '0;
    for (int i = 0; i < PASSWORD_WORDS; i++) begin
      supplied_pw[32*i +: 32] = password_q[i];
    end
  end

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  assign write_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign cmd_fire = write_go && waddr_q[7:2] == OFF_COMMAND[7:2] && wstrb_q[0]
                    && state_q == ST_IDLE;
  assign cmd_code = wdata_q[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      waddr_q       <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_q       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (write_go) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (waddr_q[7:2] == OFF_COMMAND[7:2] || waddr_q[7:2] == OFF_CONTROL[7:2]
            || is_password(waddr_q)) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // parameter sector: control word and password words [R7]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_q <= CONTROL_RESET;
      for (int i = 0; i < PASSWORD_WORDS; i++) begin
        password_q[i] <= '0;
      end
    end else if (write_go && state_q == ST_IDLE) begin
      if (waddr_q[7:2] == OFF_CONTROL[7:2]) begin
        control_q <= 16'(merge({16'h0000, control_q}, wdata_q, wstrb_q));
      end
      if (is_password(waddr_q)) begin
        password_q[waddr_q[4:2]] <= merge(password_q[waddr_q[4:2]], wdata_q, wstrb_q);
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        s_axi_rdata   <= '0;
        if (s_axi_araddr[7:2] == OFF_COMMAND[7:2]) begin
          s_axi_rdata <= {24'h000000, last_cmd_q};
        end else if (s_axi_araddr[7:2] == OFF_CONTROL[7:2]) begin
          s_axi_rdata <= {16'h0000, control_q};
        end else if (s_axi_araddr[7:2] == OFF_FLAGS[7:2]) begin
          s_axi_rdata <= {13'h0000, armed_q, lock_enabled, frozen,
                          3'b000, not_found_q, 1'b0, aborted_q, 2'b00,
                          state_q != ST_IDLE, 1'b1, 1'b0, 1'b1, 3'b000, err_q};
        end else if (s_axi_araddr[7:2] == OFF_ERASE_TIME[7:2]) begin
          s_axi_rdata <= {16'h0000, ERASE_TIME}; // [R15]
        end else if (s_axi_araddr[7:2] == OFF_PROGRESS[7:2]) begin
          s_axi_rdata <= 32'(zero_write_lba);
        end else if (is_password(s_axi_araddr)) begin
          s_axi_rdata <= password_q[s_axi_araddr[4:2]];
        end else begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // command engine
  // ---------------------------------------------------------------
  always_comb begin
    finish_abort = 1'b0;
    finish_ok    = 1'b0;
    if (cmd_fire) begin
      if (cmd_code == CMD_FREEZE_LOCK || cmd_code == CMD_ERASE_PREPARE) begin
        finish_ok = 1'b1;
      end else if (cmd_code != CMD_ERASE_UNIT || frozen || !armed_q) begin
        finish_abort = 1'b1; // [R13] [R18] [R21]
      end
    end else if (state_q == ST_CHECK) begin
      if (control_q[CTL_ERASE_MODE]) begin
        finish_abort = 1'b1; // [R9]
      end else if (!lock_enabled) begin
        finish_abort = !control_q[CTL_IDENTIFIER]; // [R10] [R12]
      end else if (control_q[CTL_IDENTIFIER]) begin
        finish_abort = supplied_pw != master_password; // [R8] [R11]
      end else begin
        finish_abort = supplied_pw != user_password; // [R8] [R11]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= ST_IDLE;
      start_q     <= 1'b0;
      aborted_q   <= 1'b0;
      not_found_q <= 1'b0;
      err_q       <= 1'b0;
      last_cmd_q  <= '0;
    end else begin
      start_q <= 1'b0;
      if (cmd_fire) begin
        last_cmd_q <= cmd_code;
      end
      if (finish_abort) begin
        state_q     <= ST_IDLE;
        aborted_q   <= 1'b1; // [R21]
        not_found_q <= 1'b0;
        err_q       <= 1'b1;
      end else if (finish_ok) begin
        aborted_q   <= 1'b0;
        not_found_q <= 1'b0;
        err_q       <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (cmd_fire) begin
              state_q <= ST_CHECK; // [R1]
            end
          end
          ST_CHECK: begin
            state_q <= ST_ERASE;
            start_q <= 1'b1;
          end
          ST_ERASE: begin
            if (walk.done) begin
              state_q     <= ST_IDLE;
              aborted_q   <= 1'b0;
              not_found_q <= walk.failed;
              err_q       <= walk.failed;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign walk.start = start_q;

  // prepare arms only the command that directly follows it [R13] [R20]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
    end else if (cmd_fire) begin
      armed_q <= cmd_code == CMD_ERASE_PREPARE; // [R20]
    end
  end

  // frozen is cleared by nothing but the power-on reset [R17] [R19]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frozen <= 1'b0;
    end else if (cmd_fire && cmd_code == CMD_FREEZE_LOCK) begin
      frozen <= 1'b1; // [R16] [R17]
    end
  end

  // successful erase completion turns the lock off; stored master password is untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_enabled <= 1'b0;
    end else if (lock_enable_set) begin
      lock_enabled <= 1'b1;
    end else if (state_q == ST_ERASE && walk.done && !walk.failed) begin
      lock_enabled <= 1'b0; // [R14]
    end
  end

  erase_sector_walker #(
    .LBA_W (LBA_W)
  ) u_walker (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .walk                 (walk),
    .highest_native_block (highest_native_block),
    .zero_write_valid     (zero_write_valid),
    .zero_write_lba       (zero_write_lba),
    .zero_write_ready     (zero_write_ready),
    .zero_write_error     (zero_write_error)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_freeze_entry: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
    cmd_fire && cmd_code == CMD_FREEZE_LOCK |=> frozen && !err_q)
    else $error("freeze did not take effect");
  a_freeze_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
    frozen |=> frozen)
    else $error("frozen state was left");
  a_frozen_reject: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
    cmd_fire && frozen && cmd_code == CMD_ERASE_UNIT |=> state_q == ST_IDLE && aborted_q)
    else $error("erase accepted while frozen");
  a_abort_flags: assert property (@(posedge aclk) disable iff (!aresetn) // [R21]
    finish_abort |=> aborted_q && err_q && state_q == ST_IDLE)
    else $error("abort not reported");
  a_prepare_needed: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    $rose(state_q == ST_CHECK) |-> $past(armed_q))
    else $error("erase ran without prepare");
  a_user_lock_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    state_q == ST_CHECK && !lock_enabled && !control_q[CTL_IDENTIFIER]
      |=> !zero_write_valid ##1 !zero_write_valid)
    else $error("user erase with lock off was not aborted");
  a_lock_cleared: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    state_q == ST_ERASE && walk.done && !walk.failed && !lock_enable_set |=> !lock_enabled)
    else $error("lock still on after erase");
endmodule // security_erase_freeze
`default_nettype wire

// File: shared/security_cmd_pkg.sv
// constants for the erase and freeze command block
// assumes an AXI4-Lite master with 32-bit data and a media sector writer
// Notes on behaviour
// R1 - command code F4h written to the command register requests the erase
// R2 - erase writes every sector from block 0 up to the highest native block
// R3 - host-visible reduced maximum address is ignored; hidden area is erased too
// R4 - erased sectors are filled with zero by writes only, never read back
// R5 - no read-back verification of erased sectors
// R6 - defective and reassigned sector lists are left untouched
// R7 - parameter sector: control word, 32-byte password, rest reserved
// R8 - control bit 0 picks master (1) or user (0) password to compare
// R9 - control bit 1 picks enhanced mode; only normal mode is supported
// R10 - lock off and user password selected ends the erase as aborted
// R11 - password mismatch aborts the erase
// R12 - lock off and otherwise acceptable: erase without any password compare
// R13 - erase not directly preceded by erase-prepare is aborted
// R14 - after erase the lock is off but the master password stays stored
// R15 - expected erase time is reported as identification word 89
// R16 - command code F5h requests the frozen state
// R17 - freeze command enters the frozen state at once
// R18 - while frozen, set-password, unlock, disable-password and erase are rejected
// R19 - frozen state is left only on power removal
// R20 - erase-prepare code F3h, no data, arms the following erase
// R21 - rejection sets aborted error bit and error-summary status bit, busy clear
package security_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_COMMAND    = 8'h00;
  localparam logic [7:0] OFF_CONTROL    = 8'h04;
  localparam logic [7:0] OFF_FLAGS      = 8'h08;
  localparam logic [7:0] OFF_ERASE_TIME = 8'h0C;
  localparam logic [7:0] OFF_PROGRESS   = 8'h10;
  localparam logic [7:0] OFF_PASSWORD   = 8'h20;
  localparam int         PASSWORD_WORDS = 8;
  // command codes
  localparam logic [7:0] CMD_SET_PASSWORD     = 8'hF1;
  localparam logic [7:0] CMD_UNLOCK           = 8'hF2;
  localparam logic [7:0] CMD_ERASE_PREPARE    = 8'hF3;
  localparam logic [7:0] CMD_ERASE_UNIT       = 8'hF4;
  localparam logic [7:0] CMD_FREEZE_LOCK      = 8'hF5;
  localparam logic [7:0] CMD_DISABLE_PASSWORD = 8'hF6;
  // control word fields
  localparam int CTL_IDENTIFIER = 0;
  localparam int CTL_ERASE_MODE = 1;
  // device_condition_flags bits
  localparam int ST_IN_PROGRESS   = 7;
  localparam int ST_READY         = 6;
  localparam int ST_DEVICE_FAULT  = 5;
  localparam int ST_SEEK_SETTLED  = 4;
  localparam int ST_ERROR_SUMMARY = 0;
  // command_error_flags bits
  localparam int ER_SECTOR_NOT_FOUND = 4;
  localparam int ER_COMMAND_ABORTED  = 2;
  // fields of the flags word
  localparam int FL_ERROR_LSB = 8;
  localparam int FL_FROZEN    = 16;
  localparam int FL_LOCK      = 17;
  localparam int FL_ARMED     = 18;
  // reset values and AXI response codes
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage

// File: shared/erase_walk_if.sv
// handshake between the command engine and the sector walker
// assumes both ends run on one clock
`timescale 1ns/1ps
`default_nettype none
interface erase_walk_if;
  logic start;
  logic done;
  logic failed;
  modport engine (output start, input done, input failed);
  modport walker (input start, output done, output failed);
endinterface
`default_nettype wire

// File: src/erase_sector_walker.sv
// walks native sectors from block 0 to the highest native block, stopping at a write error, and issues zero-fill writes to the media
// assumes the media acknowledges each write with ready, error alongside
`timescale 1ns/1ps
`default_nettype none
module erase_sector_walker
  import security_cmd_pkg::*;
#(
  parameter int LBA_W = 32
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  erase_walk_if.walker          walk,
  input  wire logic [LBA_W-1:0] highest_native_block,
  output logic                  zero_write_valid,
  output logic [LBA_W-1:0]      zero_write_lba,
  input  wire logic             zero_write_ready,
  input  wire logic             zero_write_error
);

  // ---------------------------------------------------------------
  // sector walk
  // ---------------------------------------------------------------
  // only zero-fill writes leave this block; there is no read or
  // defect-list port, so nothing is verified or remapped [R4] [R5] [R6]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_write_valid <= 1'b0;
      zero_write_lba   <= '0;
      walk.done        <= 1'b0;
      walk.failed      <= 1'b0;
    end else begin
      walk.done   <= 1'b0;
      walk.failed <= 1'b0;
      if (walk.start && !zero_write_valid) begin
        zero_write_lba   <= '0; // [R2]
        zero_write_valid <= 1'b1;
      end else if (zero_write_valid && zero_write_ready) begin
        if (zero_write_error) begin
          zero_write_valid <= 1'b0;
          walk.done        <= 1'b1;
          walk.failed      <= 1'b1;
        end else if (zero_write_lba == highest_native_block) begin // [R2] [R3]
          zero_write_valid <= 1'b0;
          walk.done        <= 1'b1;
        end else begin
          zero_write_lba <= zero_write_lba + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_walk_from_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    $rose(zero_write_valid) |-> zero_write_lba == '0)
    else $error("walk did not start at block zero");
  a_walk_in_range: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    zero_write_valid |-> zero_write_lba <= highest_native_block)
    else $error("walk went past the native end");
  a_walk_advance: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    zero_write_valid && zero_write_ready && !zero_write_error
      && zero_write_lba != highest_native_block
      |=> zero_write_valid && zero_write_lba == $past(zero_write_lba) + 1'b1)
    else $error("walk skipped a sector");
endmodule // erase_sector_walker
`default_nettype wire

// File: testbench/zero_fill_media.sv
// media model that takes zero-fill sector writes
// assumes the command engine's clock and reset
`timescale 1ns/1ps
`default_nettype none
module zero_fill_media (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        valid,
  input  wire logic [31:0] lba,
  output logic             ready,
  output logic             error,
  input  wire logic [3:0]  stall,
  input  wire logic        fail_en,
  input  wire logic [31:0] fail_lba,
  output logic [31:0]      count,
  output logic [31:0]      last_lba
);
  logic [3:0] wait_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_q   <= 4'h0;
      ready    <= 1'b0;
      error    <= 1'b0;
      count    <= 32'h0;
      last_lba <= 32'h0;
    end else begin
      ready <= 1'b0;
      // error means nothing without ready, so it keeps moving
      error <= ~error;
      if (valid && ready) begin
        count    <= count + 32'h1;
        last_lba <= lba;
      end
      if (valid && !ready) begin
        if (wait_q == stall) begin
          ready  <= 1'b1;
          error  <= fail_en && (lba == fail_lba);
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule // zero_fill_media
`default_nettype wire

// File: testbench/test_security_erase_freeze.sv
// bench for the erase and freeze command block
// assumes the media model beside it and an AXI4-Lite master in here
`timescale 1ns/1ps
`default_nettype none
module test_security_erase_freeze;
  import security_cmd_pkg::*;
  localparam logic [31:0] LAST = 32'h0000_0005;
  localparam logic [15:0] ETIME = 16'h0ABC;
  localparam logic [255:0] UPW = {8{32'h1234_5678}};
  localparam logic [255:0] MPW = {8{32'hA5A5_0F0F}};
  localparam logic [15:0] OKF = 16'((1 << ST_READY) | (1 << ST_SEEK_SETTLED));
  localparam logic [15:0] ABF = OKF | 16'((1 << ST_ERROR_SUMMARY)
                                | (1 << (FL_ERROR_LSB + ER_COMMAND_ABORTED)));
  localparam logic [31:0] NFF = 32'((1 << ST_ERROR_SUMMARY)
                                | (1 << (FL_ERROR_LSB + ER_SECTOR_NOT_FOUND)));
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, count, last_lba, f, n0;
  logic [3:0] s_axi_wstrb = 4'h0, stall = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, lock_enable_set = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic zero_write_valid, zero_write_ready, zero_write_error, frozen, lock_enabled;
  logic [31:0] zero_write_lba;
  logic fail_en = 1'b0;
  int err_count = 0, checks = 0;

  always #25 aclk = ~aclk;

  security_erase_freeze #(.LBA_W(32), .ERASE_TIME(ETIME)) dut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .user_password(UPW), .master_password(MPW), .lock_enable_set(lock_enable_set),
    .highest_native_block(LAST), .zero_write_valid(zero_write_valid),
    .zero_write_lba(zero_write_lba), .zero_write_ready(zero_write_ready),
    .zero_write_error(zero_write_error), .frozen(frozen), .lock_enabled(lock_enabled));

  zero_fill_media media (.aclk(aclk), .aresetn(aresetn), .valid(zero_write_valid),
    .lba(zero_write_lba), .ready(zero_write_ready), .error(zero_write_error),
    .stall(stall), .fail_en(fail_en), .fail_lba(32'h0000_0002), .count(count),
    .last_lba(last_lba));

  // ----------------------------------------
  // bus cycles and judging
  // ----------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang;
    err_count++;
    $display("BAD %0t wait limit reached", $time);
    results();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    if (n >= 40) hang();
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    f = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (n >= 40) hang();
  endtask

  // issue a command and poll until the engine is idle again
  task automatic cmd(input logic [7:0] code);
    int n;
    wr(OFF_COMMAND, {24'h0, code});
    n = 0;
    do begin
      rd(OFF_FLAGS);
      n++;
    end while (f[ST_IN_PROGRESS] !== 1'b0 && n < 200);
    if (n >= 200) hang();
  endtask

  task automatic lock_on;
    @(posedge aclk);
    lock_enable_set <= 1'b1;
    @(posedge aclk);
    lock_enable_set <= 1'b0;
  endtask

  task automatic erase(input logic [15:0] ctl, input logic [255:0] pw);
    n0 = count;
    wr(OFF_CONTROL, {16'h0, ctl});
    for (int i = 0; i < PASSWORD_WORDS; i++) wr(OFF_PASSWORD + 8'(4 * i), pw[32 * i +: 32]);
    cmd(CMD_ERASE_PREPARE);
    cmd(CMD_ERASE_UNIT);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_idle_regs;
    rd(OFF_FLAGS);
    check({16'h0, f[15:0]}, {16'h0, OKF});
    check({30'h0, f[FL_FROZEN], f[FL_LOCK]}, 32'h0);
    rd(OFF_ERASE_TIME);
    check(f, {16'h0, ETIME});
    rd(8'h40);
    check({30'h0, s_axi_rresp}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'h0000_0000);
    check({30'h0, s_axi_bresp}, {30'h0, RESP_SLVERR});
  endtask

  task automatic t_refused;
    logic [7:0] codes [4] = '{CMD_SET_PASSWORD, CMD_UNLOCK, CMD_DISABLE_PASSWORD, 8'h00};
    cmd(CMD_ERASE_UNIT);
    check({16'h0, f[15:0]}, {16'h0, ABF});
    cmd(CMD_ERASE_PREPARE);
    check({31'h0, f[FL_ARMED]}, 32'h1);
    cmd(CMD_SET_PASSWORD);
    cmd(CMD_ERASE_UNIT);
    check({16'h0, f[15:0]}, {16'h0, ABF});
    foreach (codes[i]) begin
      cmd(codes[i]);
      check({16'h0, f[15:0]}, {16'h0, ABF});
    end
    erase(16'h0000, UPW);
    check({16'h0, f[15:0]}, {16'h0, ABF});
    erase(16'h0003, MPW);
    check({16'h0, f[15:0]}, {16'h0, ABF});
    check(count, 32'h0);
    rd(OFF_CONTROL);
    check(f, 32'h0000_0003);
    rd(OFF_PASSWORD + 8'h04);
    check(f, MPW[63:32]);
  endtask

  task automatic t_erase_locked(input logic [15:0] ctl, input logic [255:0] pw);
    lock_on();
    erase(ctl, pw ^ 256'h1);
    check({16'h0, f[15:0]}, {16'h0, ABF});
    check({31'h0, lock_enabled}, 32'h1);
    stall <= 4'h3;
    erase(ctl, pw);
    check({16'h0, f[15:0]}, {16'h0, OKF});
    check(count - n0, LAST + 32'h1);
    check(last_lba, LAST);
    check({31'h0, lock_enabled}, 32'h0);
    rd(OFF_PROGRESS);
    check(f, LAST);
    stall <= 4'h0;
  endtask

  task automatic t_open_and_fault;
    erase(16'h0001, 256'h0);
    check(count - n0, LAST + 32'h1);
    lock_on();
    fail_en <= 1'b1;
    erase(16'h0000, UPW);
    check(f & NFF, NFF);
    check(count - n0, 32'h3);
    check({31'h0, lock_enabled}, 32'h1);
    fail_en <= 1'b0;
  endtask

  task automatic t_freeze;
    wr(OFF_COMMAND, {24'h0, CMD_FREEZE_LOCK});
    check({31'h0, frozen}, 32'h1);
    n0 = count;
    cmd(CMD_ERASE_PREPARE);
    cmd(CMD_ERASE_UNIT);
    check({16'h0, f[15:0]}, {16'h0, ABF});
    cmd(CMD_UNLOCK);
    check({16'h0, f[15:0]}, {16'h0, ABF});
    check(count, n0);
    check({31'h0, f[FL_FROZEN]}, 32'h1);
    check({31'h0, frozen}, 32'h1);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_idle_regs();
    t_refused();
    t_erase_locked(16'h0001, MPW);
    t_erase_locked(16'h0000, UPW);
    t_open_and_fault();
    t_freeze();
    results();
  end
endmodule // test_security_erase_freeze
`default_nettype wire
